// ==== hw/gtu_pkg.sv ====
// constants, field positions and types for the split timer input and reload select block
// assumes one 40 MHz clock, word-aligned register port, byte offsets
//
// Functional notes
// - part source code: 00 clock, 01 global zero, 10 global one, 11 carry
// - eight part selectors, two bits each, first timer A-D then second timer A-D
// - parts A-C: reload bit 0 own overflow, 1 reload with next higher part
// - part D reload bit 1 follows the other timer's part A reload
// - carry select bit picks own or other timer's part D carry for part A
// - global count zero: low half wrap, rise, fall or both edges of line zero
// - global count one: high half wrap, rise, fall or both edges of line one
// - reserved bits read zero and ignore writes
// - output, trigger and request selectors pick part A, B, C or D overflow
// - selector order out, trigger, request from bit 0, second timer at bit 16
// - full views hold D C B A from top byte down, read and write
// - 24-bit count views read top byte zero and never touch part D
// - 24-bit reload views read top byte zero and never touch reload D
// - low input select serves whole third timer, or its low half when split
// - high input select acts only in split mode
// - seven 3-bit function selectors at bit 0,4,8,12,16,20,24
// - codes 000-011 pick lines 0-3, paired with triggers 00-11
// - codes 100-111 pick lines 4-7, paired with triggers 00-11 again
// - edge register sets the active edge per selected function
// - edge code 00 uses paired trigger, 01 rise, 10 fall, 11 both
// - selected line events are offered as request sources regardless of use
// - all registers clear to zero at reset
package gtu_pkg;

   localparam int unsigned GTU_ADDR_W = 8;

   localparam logic [7:0] GTU_OFS_INPUT_RELOAD = 8'h10;
   localparam logic [7:0] GTU_OFS_OUT_TRIG_REQ = 8'h14;
   localparam logic [7:0] GTU_OFS_LOW_INPUT = 8'h20;
   localparam logic [7:0] GTU_OFS_HIGH_INPUT = 8'h24;
   localparam logic [7:0] GTU_OFS_EDGE = 8'h28;
   localparam logic [7:0] GTU_OFS_T0_COUNT_FULL = 8'h34;
   localparam logic [7:0] GTU_OFS_T0_COUNT_LOW24 = 8'h38;
   localparam logic [7:0] GTU_OFS_T0_RELOAD_FULL = 8'h3c;
   localparam logic [7:0] GTU_OFS_T0_RELOAD_LOW24 = 8'h40;
   localparam logic [7:0] GTU_OFS_T1_COUNT_FULL = 8'h44;
   localparam logic [7:0] GTU_OFS_T1_COUNT_LOW24 = 8'h48;
   localparam logic [7:0] GTU_OFS_T1_RELOAD_FULL = 8'h4c;
   localparam logic [7:0] GTU_OFS_T1_RELOAD_LOW24 = 8'h50;

   // writable bits; everything else is reserved
   localparam logic [31:0] GTU_MASK_INPUT_RELOAD = 32'hf3ffffff;
   localparam logic [31:0] GTU_MASK_OUT_TRIG_REQ = 32'h0fff0fff;
   localparam logic [31:0] GTU_MASK_INPUT_SEL = 32'h07777777;
   localparam logic [31:0] GTU_MASK_EDGE = 32'h3fff3fff;
   localparam logic [31:0] GTU_MASK_LOW24 = 32'h00ffffff;
   localparam logic [31:0] GTU_RESET_VALUE = 32'h00000000;
   localparam logic [7:0] GTU_PART_RESET = 8'h00;
   localparam logic [7:0] GTU_PART_MAX = 8'hff;

   localparam int unsigned GTU_POS_RELOAD = 16;
   localparam int unsigned GTU_POS_CARRY = 24;
   localparam int unsigned GTU_POS_GLOBAL0 = 28;
   localparam int unsigned GTU_POS_GLOBAL1 = 30;
   localparam int unsigned GTU_POS_SECOND = 16;
   localparam int unsigned GTU_FUNC_STRIDE = 4;
   localparam int unsigned GTU_EDGE_STRIDE = 2;
   localparam int unsigned GTU_NUM_FUNC = 7;

   typedef enum logic [1:0] {
      GTU_SRC_CLOCK = 2'b00,
      GTU_SRC_GLOBAL0 = 2'b01,
      GTU_SRC_GLOBAL1 = 2'b10,
      GTU_SRC_CARRY = 2'b11
   } gtu_source_type;

   typedef enum logic [1:0] {
      GTU_EDGE_NONE = 2'b00,
      GTU_EDGE_RISE = 2'b01,
      GTU_EDGE_FALL = 2'b10,
      GTU_EDGE_BOTH = 2'b11
   } gtu_edge_type;

endpackage

// ==== hw/gtu_split_timer.sv ====
// two split 8-bit-part timers with input, reload, carry and overflow routing,
// plus the input and edge selection for the third timer's functions
// assumes a simple strobe register port and ext lines arriving from pins
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module gtu_split_timer
   import gtu_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [31:0] rdata,
   input wire logic [7:0] external_input_line,
   input wire logic low_half_wrap_event,
   input wire logic high_half_wrap_event,
   input wire logic split_mode,
   output logic [3:0] timer_output,
   output logic [3:0] cross_timer_trigger,
   output logic [3:0] request_event,
   output logic [6:0] low_function_event,
   output logic [6:0] high_function_event,
   output logic [1:0] direction_level
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // parts a write touches: all four, low three or none; count and reload alike
   function automatic logic [3:0] part_write_mask(input logic [7:0] a, input logic [7:0] full,
      input logic [7:0] low24);
      logic [3:0] m;
      m = 4'h0;
      if (a == full)
         m = 4'hf;
      else if (a == low24)
         m = 4'h7;
      return m;
   endfunction

   function automatic logic edge_pick(input logic [1:0] mode, input logic rise, input logic fall,
      input logic alt);
      logic hit;
      hit = 1'b0;
      unique case (gtu_edge_type'(mode))
         GTU_EDGE_NONE: hit = alt;
         GTU_EDGE_RISE: hit = rise;
         GTU_EDGE_FALL: hit = fall;
         GTU_EDGE_BOTH: hit = rise | fall;
      endcase
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // control registers

   logic [31:0] input_reload_reg;
   logic [31:0] out_trig_req_reg;
   logic [31:0] low_half_input_select_reg;
   logic [31:0] high_half_input_select_reg;
   logic [31:0] input_edge_select_reg;
   logic wr_en;

   assign wr_en = write_strobe;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         input_reload_reg <= GTU_RESET_VALUE;
         out_trig_req_reg <= GTU_RESET_VALUE;
         low_half_input_select_reg <= GTU_RESET_VALUE;
         high_half_input_select_reg <= GTU_RESET_VALUE;
         input_edge_select_reg <= GTU_RESET_VALUE;
      end
      else if (wr_en)
      begin
         if (addr == GTU_OFS_INPUT_RELOAD)
            input_reload_reg <= wdata & GTU_MASK_INPUT_RELOAD;
         if (addr == GTU_OFS_OUT_TRIG_REQ)
            out_trig_req_reg <= wdata & GTU_MASK_OUT_TRIG_REQ;
         if (addr == GTU_OFS_LOW_INPUT)
            low_half_input_select_reg <= wdata & GTU_MASK_INPUT_SEL;
         if (addr == GTU_OFS_HIGH_INPUT)
            high_half_input_select_reg <= wdata & GTU_MASK_INPUT_SEL;
         if (addr == GTU_OFS_EDGE)
            input_edge_select_reg <= wdata & GTU_MASK_EDGE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // external lines: two-flop sync, then a third copy for edges

   logic [7:0] ext_meta_reg;
   logic [7:0] ext_sync_reg;
   logic [7:0] ext_last_reg;
   logic [7:0] ext_rise;
   logic [7:0] ext_fall;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         ext_meta_reg <= 8'h00;
         ext_sync_reg <= 8'h00;
         ext_last_reg <= 8'h00;
      end
      else
      begin
         ext_meta_reg <= external_input_line;
         ext_sync_reg <= ext_meta_reg;
         ext_last_reg <= ext_sync_reg;
      end
   end

   assign ext_rise = ext_sync_reg & ~ext_last_reg;
   assign ext_fall = ~ext_sync_reg & ext_last_reg;

   ////////////////////////////////////////////////////////////////////////
   // global count inputs

   logic global_count_zero;
   logic global_count_one;

   assign global_count_zero = edge_pick(input_reload_reg[GTU_POS_GLOBAL0 +: 2], ext_rise[0],
      ext_fall[0], low_half_wrap_event);
   // code 00 follows the high half wrap; the low half wrap is not offered here
   assign global_count_one = edge_pick(input_reload_reg[GTU_POS_GLOBAL1 +: 2], ext_rise[1],
      ext_fall[1], high_half_wrap_event);

   ////////////////////////////////////////////////////////////////////////
   // timer parts: index t*4+p, p 0..3 for parts A..D

   logic [7:0] count_reg [0:7];
   logic [7:0] reload_reg [0:7];
   wire [7:0] part_ovf;
   wire [7:0] part_reload;
   logic [1:0] chain_carry_reg;
   logic [1:0] cross_reload_reg;
   logic [3:0] cnt_wmask [0:1];
   logic [3:0] rld_wmask [0:1];

   // cross-timer paths are registered: all-carry or all-concatenated setups
   // would otherwise form a combinational ring, at the cost of one cycle
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         chain_carry_reg <= 2'b00;
         cross_reload_reg <= 2'b00;
      end
      else
      begin
         chain_carry_reg[0] <= input_reload_reg[GTU_POS_CARRY] ? part_ovf[7] : part_ovf[3];
         chain_carry_reg[1] <= input_reload_reg[GTU_POS_CARRY + 1] ? part_ovf[3] : part_ovf[7];
         cross_reload_reg[0] <= part_reload[4];
         cross_reload_reg[1] <= part_reload[0];
      end
   end

   genvar gt, gp;
   generate
      for (gt = 0; gt < 2; gt++)
      begin : g_timer
         always_comb
         begin
            cnt_wmask[gt] = 4'h0;
            rld_wmask[gt] = 4'h0;
            if (wr_en)
            begin
               cnt_wmask[gt] = (gt == 0) ?
                  part_write_mask(addr, GTU_OFS_T0_COUNT_FULL, GTU_OFS_T0_COUNT_LOW24) :
                  part_write_mask(addr, GTU_OFS_T1_COUNT_FULL, GTU_OFS_T1_COUNT_LOW24);
               rld_wmask[gt] = (gt == 0) ?
                  part_write_mask(addr, GTU_OFS_T0_RELOAD_FULL, GTU_OFS_T0_RELOAD_LOW24) :
                  part_write_mask(addr, GTU_OFS_T1_RELOAD_FULL, GTU_OFS_T1_RELOAD_LOW24);
            end
         end

         for (gp = 0; gp < 4; gp++)
         begin : g_part
            localparam int IDX = gt * 4 + gp;
            logic [1:0] src;
            logic carry_in;
            logic step;
            logic rel;

            assign src = input_reload_reg[IDX * 2 +: 2];
            assign rel = input_reload_reg[GTU_POS_RELOAD + IDX];
            if (gp == 0)
            begin : g_low
               assign carry_in = chain_carry_reg[gt];
            end
            else
            begin : g_up
               assign carry_in = part_ovf[IDX - 1];
            end

            always_comb
            begin
               step = 1'b0;
               unique case (gtu_source_type'(src))
                  GTU_SRC_CLOCK: step = 1'b1;
                  GTU_SRC_GLOBAL0: step = global_count_zero;
                  GTU_SRC_GLOBAL1: step = global_count_one;
                  GTU_SRC_CARRY: step = carry_in;
               endcase
            end

            assign part_ovf[IDX] = step & (count_reg[IDX] == GTU_PART_MAX);
            if (gp < 3)
            begin : g_rel_abc
               assign part_reload[IDX] = rel ? part_reload[IDX + 1] : part_ovf[IDX];
            end
            else
            begin : g_rel_d
               assign part_reload[IDX] = rel ? cross_reload_reg[gt] : part_ovf[IDX];
            end

            // a software write wins over counting and reload in the same cycle
            always_ff @(posedge clock or posedge reset)
            begin
               if (reset)
                  count_reg[IDX] <= GTU_PART_RESET;
               else if (cnt_wmask[gt][gp])
                  count_reg[IDX] <= wdata[gp * 8 +: 8];
               else if (part_reload[IDX])
                  count_reg[IDX] <= reload_reg[IDX];
               else if (step)
                  count_reg[IDX] <= count_reg[IDX] + 8'h01;
            end

            always_ff @(posedge clock or posedge reset)
            begin
               if (reset)
                  reload_reg[IDX] <= GTU_PART_RESET;
               else if (rld_wmask[gt][gp])
                  reload_reg[IDX] <= wdata[gp * 8 +: 8];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // overflow routing: six selectors per timer

   wire [11:0] route_hit;
   logic [11:0] route_pulse_reg;

   genvar gs;
   generate
      for (gs = 0; gs < 12; gs++)
      begin : g_route
         localparam int T = gs / 6;
         localparam int J = gs % 6;
         logic [1:0] part_sel;
         assign part_sel = out_trig_req_reg[T * GTU_POS_SECOND + J * 2 +: 2];
         assign route_hit[gs] = part_ovf[T * 4 + int'(part_sel)];
      end
   endgenerate

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         route_pulse_reg <= 12'h000;
      else
         route_pulse_reg <= route_hit;
   end

   assign timer_output = {route_pulse_reg[7:6], route_pulse_reg[1:0]};
   assign cross_timer_trigger = {route_pulse_reg[9:8], route_pulse_reg[3:2]};
   assign request_event = {route_pulse_reg[11:10], route_pulse_reg[5:4]};

   ////////////////////////////////////////////////////////////////////////
   // third timer input selection, both halves

   wire [13:0] func_hit;
   wire [1:0] dir_hit;
   logic [13:0] func_event_reg;
   logic [1:0] dir_level_reg;

   genvar gh, gf;
   generate
      for (gh = 0; gh < 2; gh++)
      begin : g_half
         for (gf = 0; gf < GTU_NUM_FUNC; gf++)
         begin : g_func
            logic [2:0] code;
            logic [1:0] edge_mode;
            logic alt;
            // only count and the two reload/capture functions have a trigger pair
            localparam bit PAIRED = (gf == 0) || (gf == 5) || (gf == 6);
            if (gh == 0)
            begin : g_lo
               assign code = low_half_input_select_reg[gf * GTU_FUNC_STRIDE +: 3];
            end
            else
            begin : g_hi
               assign code = high_half_input_select_reg[gf * GTU_FUNC_STRIDE +: 3];
            end
            assign edge_mode = input_edge_select_reg[gh * GTU_POS_SECOND +
               gf * GTU_EDGE_STRIDE +: 2];
            assign alt = PAIRED ? route_pulse_reg[(int'(code[1]) * 6) + 2 + int'(code[0])]
               : 1'b0;
            assign func_hit[gh * GTU_NUM_FUNC + gf] = edge_pick(edge_mode, ext_rise[code],
               ext_fall[code], alt);
            if (gf == 3)
            begin : g_dir
               assign dir_hit[gh] = ext_sync_reg[code];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         func_event_reg <= 14'h0000;
         dir_level_reg <= 2'b00;
      end
      else
      begin
         func_event_reg[6:0] <= func_hit[6:0];
         func_event_reg[13:7] <= split_mode ? func_hit[13:7] : 7'h00;
         dir_level_reg <= {dir_hit[1] & split_mode, dir_hit[0]};
      end
   end

   assign low_function_event = func_event_reg[6:0];
   assign high_function_event = func_event_reg[13:7];
   assign direction_level = dir_level_reg;

   ////////////////////////////////////////////////////////////////////////
   // read port: data in the cycle after the strobe, zero otherwise

   logic [31:0] read_value;
   logic [31:0] rdata_reg;

   always_comb
   begin
      read_value = GTU_RESET_VALUE;
      unique case (addr)
         GTU_OFS_INPUT_RELOAD: read_value = input_reload_reg;
         GTU_OFS_OUT_TRIG_REQ: read_value = out_trig_req_reg;
         GTU_OFS_LOW_INPUT: read_value = low_half_input_select_reg;
         GTU_OFS_HIGH_INPUT: read_value = high_half_input_select_reg;
         GTU_OFS_EDGE: read_value = input_edge_select_reg;
         GTU_OFS_T0_COUNT_FULL:
            read_value = {count_reg[3], count_reg[2], count_reg[1], count_reg[0]};
         GTU_OFS_T0_COUNT_LOW24:
            read_value = {8'h00, count_reg[2], count_reg[1], count_reg[0]};
         GTU_OFS_T0_RELOAD_FULL:
            read_value = {reload_reg[3], reload_reg[2], reload_reg[1], reload_reg[0]};
         GTU_OFS_T0_RELOAD_LOW24:
            read_value = {8'h00, reload_reg[2], reload_reg[1], reload_reg[0]};
         GTU_OFS_T1_COUNT_FULL:
            read_value = {count_reg[7], count_reg[6], count_reg[5], count_reg[4]};
         GTU_OFS_T1_COUNT_LOW24:
            read_value = {8'h00, count_reg[6], count_reg[5], count_reg[4]};
         GTU_OFS_T1_RELOAD_FULL:
            read_value = {reload_reg[7], reload_reg[6], reload_reg[5], reload_reg[4]};
         GTU_OFS_T1_RELOAD_LOW24:
            read_value = {8'h00, reload_reg[6], reload_reg[5], reload_reg[4]};
         default: read_value = GTU_RESET_VALUE;
      endcase
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         rdata_reg <= GTU_RESET_VALUE;
      else if (read_strobe)
         rdata_reg <= read_value;
      else
         rdata_reg <= GTU_RESET_VALUE;
   end

   assign rdata = rdata_reg;

endmodule

`default_nettype wire

// ==== sim/gtu_pin_model.sv ====
// pin-side model: the eight external input lines seen by the timer block
// assumes the bench says which level each line should take
`timescale 1ns/1ps
`default_nettype none

module gtu_pin_model
(
   input wire logic clock,
   input wire logic [7:0] want,
   output logic [7:0] line
);
   initial line = 8'h00;
   // pins are asynchronous: move away from the edge so sync flops see real skew
   always @(posedge clock)
   begin
      line <= #7 want;
   end
endmodule

`default_nettype wire

// ==== sim/gtu_split_timer_checker.sv ====
// checker for the split timer block: read-back shape and split gating
// assumes it is bound to gtu_split_timer and sees its ports only
`timescale 1ns/1ps
`default_nettype none

module gtu_split_timer_checker
   import gtu_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic read_strobe,
   input wire logic [31:0] rdata,
   input wire logic split_mode,
   input wire logic [3:0] timer_output,
   input wire logic [6:0] high_function_event,
   input wire logic [1:0] direction_level
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   ///////////////////////////////////////////////////////////////
   AST_RD_IDLE: assert property (!read_strobe |=> rdata == 32'h0)
      else $error("read data not zero outside read slot");
   AST_UNMAPPED: assert property (read_strobe && addr == 8'h00 |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   AST_IRS_RSV: assert property (read_strobe && addr == GTU_OFS_INPUT_RELOAD
      |=> rdata[27:26] == 2'b00)
      else $error("input reload reserved bits set");
   AST_OTS_RSV: assert property (read_strobe && addr == GTU_OFS_OUT_TRIG_REQ
      |=> (rdata & ~GTU_MASK_OUT_TRIG_REQ) == 32'h0)
      else $error("route select reserved bits set");
   AST_AIS_RSV: assert property (read_strobe && addr == GTU_OFS_LOW_INPUT
      |=> (rdata & ~GTU_MASK_INPUT_SEL) == 32'h0)
      else $error("input select reserved bits set");
   AST_EDGE_RSV: assert property (read_strobe && addr == GTU_OFS_EDGE
      |=> (rdata & ~GTU_MASK_EDGE) == 32'h0)
      else $error("edge select reserved bits set");
   AST_LOW24: assert property (read_strobe && (addr == GTU_OFS_T0_COUNT_LOW24
      || addr == GTU_OFS_T0_RELOAD_LOW24 || addr == GTU_OFS_T1_COUNT_LOW24
      || addr == GTU_OFS_T1_RELOAD_LOW24) |=> rdata[31:24] == 8'h00)
      else $error("low24 view top byte not zero");
   // three cycles: gating may act one register stage late
   AST_HIGH_OFF: assert property ((!split_mode) [*3] |-> high_function_event == 7'h0)
      else $error("high half event while not split");
   AST_DIR_OFF: assert property ((!split_mode) [*3] |-> !direction_level[1])
      else $error("high direction level while not split");
   AST_RST: assert property ($fell(reset) |-> timer_output == 4'h0 && rdata == 32'h0)
      else $error("outputs not clear after reset");
endmodule

bind gtu_split_timer gtu_split_timer_checker gtu_split_timer_checker_i (.clock, .reset,
   .addr, .read_strobe, .rdata, .split_mode, .timer_output, .high_function_event,
   .direction_level);

`default_nettype wire

// ==== sim/test_gtu_split_timer.sv ====
// self-checking bench for gtu_split_timer
// assumes the pin model drives the external lines and a 40 MHz clock
`timescale 1ns/1ps
`default_nettype none

`define GTU_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end

module test_gtu_split_timer;
   import gtu_pkg::*;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} gtu_row_type;
   logic clock = 1'b0, reset = 1'b1, write_strobe = 1'b0, read_strobe = 1'b0;
   logic low_half_wrap_event = 1'b0, high_half_wrap_event = 1'b0, split_mode = 1'b0;
   logic [7:0] addr = 8'h00, pin_want = 8'h00, exp;
   logic [31:0] wdata = 32'h0, v;
   logic found;
   int num_errors = 0, tests_run = 0;
   wire logic [7:0] external_input_line;
   wire logic [31:0] rdata;
   wire logic [3:0] timer_output, cross_timer_trigger, request_event;
   wire logic [6:0] low_function_event, high_function_event;
   wire logic [1:0] direction_level;
   wire logic [11:0] routed = {request_event, cross_timer_trigger, timer_output};
   // first read lands before the free-running parts leave zero
   logic [7:0] rst_ofs [10] = '{8'h34, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h3c, 8'h40, 8'h4c,
      8'h50};
   // count rows run with every part fed by global zero, which stays quiet
   gtu_row_type rows [20] = '{
      '{8'h10, 1'b1, 32'hffffffff, 32'hf3ffffff},
      '{8'h10, 1'b1, 32'h00005555, 32'h00005555},
      '{8'h14, 1'b1, 32'hffffffff, 32'h0fff0fff},
      '{8'h20, 1'b1, 32'hffffffff, 32'h07777777},
      '{8'h24, 1'b1, 32'hffffffff, 32'h07777777},
      '{8'h28, 1'b1, 32'hffffffff, 32'h3fff3fff},
      '{8'h34, 1'b1, 32'h12345678, 32'h12345678},
      '{8'h38, 1'b1, 32'haabbccdd, 32'h00bbccdd},
      '{8'h34, 1'b0, 32'h0, 32'h12bbccdd},
      '{8'h3c, 1'b1, 32'h87654321, 32'h87654321},
      '{8'h40, 1'b1, 32'hffeeddcc, 32'h00eeddcc},
      '{8'h3c, 1'b0, 32'h0, 32'h87eeddcc},
      '{8'h44, 1'b1, 32'h0a1b2c3d, 32'h0a1b2c3d},
      '{8'h48, 1'b1, 32'h11223344, 32'h00223344},
      '{8'h44, 1'b0, 32'h0, 32'h0a223344},
      '{8'h4c, 1'b1, 32'hc0ffee11, 32'hc0ffee11},
      '{8'h50, 1'b1, 32'h55667788, 32'h00667788},
      '{8'h4c, 1'b0, 32'h0, 32'hc0667788},
      '{8'h00, 1'b1, 32'hffffffff, 32'h00000000},
      '{8'h2c, 1'b1, 32'hffffffff, 32'h00000000}};

   gtu_split_timer gtu_split_timer_i (.clock, .reset, .addr, .wdata, .write_strobe,
      .read_strobe, .rdata, .external_input_line, .low_half_wrap_event,
      .high_half_wrap_event, .split_mode, .timer_output, .cross_timer_trigger,
      .request_event, .low_function_event, .high_function_event, .direction_level);
   gtu_pin_model gtu_pin_model_i (.clock, .want(pin_want), .line(external_input_line));

   always #12.5 clock = ~clock;
   ///////////////////////////////////////////////////////////////
   // trailing idle edge so a following write never re-raises the strobe in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      begin
         addr <= a;
         wdata <= d;
         write_strobe <= 1'b1;
         @(posedge clock);
         write_strobe <= 1'b0;
         @(posedge clock);
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      begin
         addr <= a;
         read_strobe <= 1'b1;
         @(posedge clock);
         read_strobe <= 1'b0;
         #1 d = rdata;
         @(posedge clock);
      end
   endtask

   task automatic end_sim;
      begin
         if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   ///////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      foreach (rst_ofs[i])
      begin
         rd(rst_ofs[i], v);
         `GTU_CHK("reset value", 32'h0, v)
      end
      foreach (rows[i])
      begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         `GTU_CHK("register row", rows[i].e, v)
      end
      // all parts on the clock, every route on part A, part A two short of wrap
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h0);
      wr(8'h3c, 32'h0);
      wr(8'h44, 32'h000000fc);
      wr(8'h34, 32'h000000fe);
      #1 `GTU_CHK("route idle", 12'h000, routed)
      @(posedge clock);
      #1 `GTU_CHK("route pulse", 12'hfff, routed)
      wr(8'h10, 32'h000000fc);
      wr(8'h34, 32'h000000fe);
      repeat (4) @(posedge clock);
      rd(8'h34, v);
      `GTU_CHK("carry chain", 24'h000001, v[31:8])
      // part a on global zero, part b on global one, both selectors stepped alike
      wr(8'h10, 32'h00000009);
      wr(8'h34, 32'h0);
      exp = 8'h00;
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h10, {c[1:0], c[1:0], 28'h0000009});
         low_half_wrap_event <= 1'b1;
         high_half_wrap_event <= 1'b1;
         @(posedge clock);
         low_half_wrap_event <= 1'b0;
         high_half_wrap_event <= 1'b0;
         pin_want[1:0] <= 2'b11;
         repeat (6) @(posedge clock);
         pin_want[1:0] <= 2'b00;
         repeat (8) @(posedge clock);
         rd(8'h34, v);
         exp = exp + ((c == 3) ? 8'h02 : 8'h01);
         `GTU_CHK("global zero count", exp, v[7:0])
         `GTU_CHK("global one count", exp, v[15:8])
      end
      split_mode <= 1'b1;
      wr(8'h20, 32'h00003002);
      wr(8'h24, 32'h00003002);
      wr(8'h28, 32'h00010001);
      pin_want[3:2] <= 2'b11;
      found = 1'b0;
      for (int n = 0; n < 10 && !found; n++)
      begin
         @(posedge clock);
         #1 found = low_function_event[0];
      end
      `GTU_CHK("low count event", 1'b1, found)
      if (found === 1'b1)
      begin
         `GTU_CHK("high count event", 1'b1, high_function_event[0])
         repeat (4) @(posedge clock);
         #1 `GTU_CHK("direction level", 2'b11, direction_level)
      end
      // second reset in mid-run, released one edge later
      @(posedge clock);
      reset <= 1'b1;
      @(posedge clock);
      reset <= 1'b0;
      rd(8'h10, v);
      `GTU_CHK("mid-run reset", 32'h0, v)
      end_sim();
   end
endmodule

`default_nettype wire
